// file: design/csbm_bank0.sv
`timescale 1ns/1ns
module csbm_bank0
	import csbm_pkg::*;
(
	// clock and reset
	input  wire logic                            CLOCK,
	input  wire logic                            SYS_RST,
	input  wire logic                            POWER_RST_KIND,
	input  wire logic                            TIMEOUT_FLAG,
	input  wire logic                            POWERDOWN_FLAG,
	// core operand path
	input  wire logic [csbm_pkg::ADDR_W-1:0]     ADDR,
	input  wire logic                            RD_EN,
	input  wire logic                            WR_EN,
	input  wire logic [csbm_pkg::DATA_W-1:0]     WR_DATA,
	output logic      [csbm_pkg::DATA_W-1:0]     RD_DATA,
	// program counter
	input  wire logic                            PC_STEP,
	output logic      [csbm_pkg::PC_W-1:0]       PC,
	// ports
	input  wire logic [csbm_pkg::PA_W-1:0]       PORT_A_PINS,
	output logic      [csbm_pkg::PA_W-1:0]       PORT_A_LATCH,
	input  wire logic [csbm_pkg::DATA_W-1:0]     PORT_B_PINS,
	output logic      [csbm_pkg::DATA_W-1:0]     PORT_B_LATCH,
	// converter and control outputs
	input  wire logic                            CONV_DONE,
	input  wire logic [csbm_pkg::DATA_W-1:0]     CONV_VALUE,
	output logic      [csbm_pkg::DATA_W-1:0]     CONV_CTRL,
	output logic      [csbm_pkg::DATA_W-1:0]     INT_CTRL,
	output logic      [csbm_pkg::DATA_W-1:0]     TIMER_VALUE,
	output logic      [csbm_pkg::DATA_W-1:0]     STATUS
);
	logic [PC_W-1:0]   pc_q;
	logic [PCH_W-1:0]  program_counter_high_latch_q;
	logic [DATA_W-1:0] status_q;
	logic [DATA_W-1:0] fsr_q;
	logic [DATA_W-1:0] timer_q;
	logic [PA_W-1:0]   pa_q;
	logic [DATA_W-1:0] pb_q;
	logic [DATA_W-1:0] intc_q;
	logic [DATA_W-1:0] pir_q;
	logic [DATA_W-1:0] converter_result_q;
	logic [DATA_W-1:0] adcon_q;
	logic [DATA_W-1:0] rd_q;
	logic              ram_sel_q;
	logic [PA_W-1:0]   pa_s1_q;
	logic [PA_W-1:0]   pa_s2_q;
	logic [DATA_W-1:0] pb_s1_q;
	logic [DATA_W-1:0] pb_s2_q;

	csbm_ram_if ram ();

	csbm_gpr_ram #(.DEPTH(GPR_DEPTH)) u_ram
	(
		.CLOCK (CLOCK),
		.ram   (ram.mem)
	);

	wire               is_ind   = (ADDR == OFS_INDIRECT);
	wire [ADDR_W-1:0]  eff_addr = is_ind ? fsr_q[ADDR_W-1:0] : ADDR;
	wire               eff_bank = is_ind ? fsr_q[DATA_W-1] : status_q[STAT_RP0];
	wire               shared   = (eff_addr == OFS_INDIRECT) || (eff_addr == OFS_PC_LOW) ||
	                              (eff_addr == OFS_STATUS) || (eff_addr == OFS_POINTER) ||
	                              (eff_addr == OFS_PC_LATCH) || (eff_addr == OFS_INT_CTRL);
	wire               visible  = !eff_bank || shared;
	wire               hit_gpr  = !eff_bank && (eff_addr >= OFS_GPR_LOW);
	wire               wr       = WR_EN && visible && !(eff_addr == OFS_INDIRECT);
	wire               wr_tmr   = wr && (eff_addr == OFS_TIMER);
	wire               wr_pcl   = wr && (eff_addr == OFS_PC_LOW);
	wire               wr_stat  = wr && (eff_addr == OFS_STATUS);
	wire               wr_fsr   = wr && (eff_addr == OFS_POINTER);
	wire               wr_pa    = wr && (eff_addr == OFS_PORT_A);
	wire               wr_pb    = wr && (eff_addr == OFS_PORT_B);
	wire               wr_plat  = wr && (eff_addr == OFS_PC_LATCH);
	wire               wr_intc  = wr && (eff_addr == OFS_INT_CTRL);
	wire               wr_pir   = wr && (eff_addr == OFS_PER_FLAGS);
	wire               wr_adc   = wr && (eff_addr == OFS_CONV_CTRL);

	assign ram.addr  = 7'(eff_addr - OFS_GPR_LOW);
	assign ram.wr_en = wr && hit_gpr;
	assign ram.wdata = WR_DATA;

	logic [DATA_W-1:0] sfr_rd;
	always_comb
	begin
		sfr_rd = ZERO_BYTE;
		if (visible)
		begin
			unique case (eff_addr)
				OFS_TIMER:     sfr_rd = timer_q;
				OFS_PC_LOW:    sfr_rd = pc_q[DATA_W-1:0];
				OFS_STATUS:    sfr_rd = status_q;
				OFS_POINTER:   sfr_rd = fsr_q;
				OFS_PORT_A:    sfr_rd = {3'h0, pa_s2_q};
				OFS_PORT_B:    sfr_rd = pb_s2_q;
				OFS_PC_LATCH:  sfr_rd = {3'h0, program_counter_high_latch_q};
				OFS_INT_CTRL:  sfr_rd = intc_q;
				OFS_PER_FLAGS: sfr_rd = pir_q & PER_FLAGS_MASK;
				OFS_CONV_RES:  sfr_rd = converter_result_q;
				OFS_CONV_CTRL: sfr_rd = adcon_q & CONV_CTRL_MASK;
				default:       sfr_rd = ZERO_BYTE;
			endcase
		end
	end

	assign RD_DATA      = ram_sel_q ? ram.rdata : rd_q;
	assign PC           = pc_q;
	assign PORT_A_LATCH = pa_q;
	assign PORT_B_LATCH = pb_q;
	assign CONV_CTRL    = adcon_q;
	assign INT_CTRL     = intc_q;
	assign TIMER_VALUE  = timer_q;
	assign STATUS       = status_q;

	// pin synchronisers
	always_ff @(posedge CLOCK)
	begin
		pa_s1_q <= PORT_A_PINS;
		pa_s2_q <= pa_s1_q;
		pb_s1_q <= PORT_B_PINS;
		pb_s2_q <= pb_s1_q;
	end

	// read return
	always_ff @(posedge CLOCK)
	begin
		if (SYS_RST)
		begin
			rd_q      <= ZERO_BYTE;
			ram_sel_q <= 1'b0;
		end
		else if (RD_EN)
		begin
			rd_q      <= sfr_rd;
			ram_sel_q <= hit_gpr;
		end
	end

	// program counter
	always_ff @(posedge CLOCK)
	begin
		if (SYS_RST)
		begin
			pc_q     <= 13'h0000;
			program_counter_high_latch_q <= 5'h00;
		end
		else
		begin
			if (wr_pcl)
				pc_q <= {program_counter_high_latch_q, WR_DATA};
			else if (PC_STEP)
				pc_q <= 13'(pc_q + 13'h0001);
			if (wr_plat)
				program_counter_high_latch_q <= WR_DATA[PCH_W-1:0];
		end
	end

	// core registers with two reset value sets
	always_ff @(posedge CLOCK)
	begin
		if (SYS_RST && POWER_RST_KIND)
		begin
			status_q <= STATUS_POWER_RST;
			fsr_q    <= ZERO_BYTE;
			timer_q  <= ZERO_BYTE;
			pa_q     <= 5'h00;
			pb_q     <= ZERO_BYTE;
			intc_q   <= ZERO_BYTE;
			converter_result_q  <= ZERO_BYTE;
		end
		else if (SYS_RST)
		begin
			status_q <= {3'h0, TIMEOUT_FLAG, POWERDOWN_FLAG, status_q[2:0]};
			pa_q     <= {pa_q[PA_W-1], 4'h0};
			intc_q   <= intc_q & INT_CTRL_KEEP;
		end
		else
		begin
			if (wr_stat)
				status_q <= (WR_DATA & STATUS_UPPER_MASK) | (status_q & ~STATUS_UPPER_MASK);
			if (wr_fsr)
				fsr_q <= WR_DATA;
			if (wr_tmr)
				timer_q <= WR_DATA;
			if (wr_pa)
				pa_q <= WR_DATA[PA_W-1:0];
			if (wr_pb)
				pb_q <= WR_DATA;
			if (wr_intc)
				intc_q <= WR_DATA;
			if (CONV_DONE)
				converter_result_q <= CONV_VALUE;
		end
	end

	// converter control and flag, done wins over a clearing write
	always_ff @(posedge CLOCK)
	begin
		if (SYS_RST)
		begin
			pir_q   <= ZERO_BYTE;
			adcon_q <= ZERO_BYTE;
		end
		else
		begin
			if (CONV_DONE)
				pir_q[FLAG_CONV] <= 1'b1;
			else if (wr_pir)
				pir_q[FLAG_CONV] <= WR_DATA[FLAG_CONV];
			if (wr_adc)
				adcon_q <= WR_DATA & CONV_CTRL_MASK;
			if (CONV_DONE)
				adcon_q[CONV_GO] <= 1'b0;
		end
	end
endmodule

// file: design/csbm_gpr_ram.sv
`timescale 1ns/1ns
module csbm_gpr_ram
	import csbm_pkg::*;
#(
	parameter int DEPTH = GPR_DEPTH
)
(
	input wire logic CLOCK,
	csbm_ram_if.mem  ram
);
	logic [DATA_W-1:0] cell_q [DEPTH];
	logic [DATA_W-1:0] rdata_q;

	assign ram.rdata = rdata_q;

	// static storage cells, no refresh
	always_ff @(posedge CLOCK)
	begin
		if (ram.wr_en)
			cell_q[ram.addr] <= ram.wdata;
		rdata_q <= cell_q[ram.addr];
	end
endmodule

// file: design/csbm_pkg.sv
package csbm_pkg;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam int PC_W = 13;
	localparam int PCH_W = 5;
	localparam int PA_W = 5;
	localparam int GPR_BASE = 32;
	localparam int GPR_DEPTH = 96;
	localparam int GPR_AW = 7;

	localparam logic [6:0] OFS_INDIRECT = 7'h00;
	localparam logic [6:0] OFS_TIMER = 7'h01;
	localparam logic [6:0] OFS_PC_LOW = 7'h02;
	localparam logic [6:0] OFS_STATUS = 7'h03;
	localparam logic [6:0] OFS_POINTER = 7'h04;
	localparam logic [6:0] OFS_PORT_A = 7'h05;
	localparam logic [6:0] OFS_PORT_B = 7'h06;
	localparam logic [6:0] OFS_PC_LATCH = 7'h0a;
	localparam logic [6:0] OFS_INT_CTRL = 7'h0b;
	localparam logic [6:0] OFS_PER_FLAGS = 7'h0c;
	localparam logic [6:0] OFS_CONV_RES = 7'h1e;
	localparam logic [6:0] OFS_CONV_CTRL = 7'h1f;
	localparam logic [6:0] OFS_GPR_LOW = 7'h20;

	localparam int STAT_RP0 = 5;
	localparam int STAT_TO = 4;
	localparam int STAT_PD = 3;
	localparam int FLAG_CONV = 6;
	localparam int CONV_GO = 2;
	localparam int CONV_GAP = 1;

	localparam logic [7:0] STATUS_POWER_RST = 8'h18;
	localparam logic [7:0] STATUS_UPPER_MASK = 8'he0;
	localparam logic [7:0] CONV_CTRL_MASK = 8'hfd;
	localparam logic [7:0] PER_FLAGS_MASK = 8'h40;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [7:0] INT_CTRL_KEEP = 8'h01;
endpackage

// file: design/csbm_ram_if.sv
`timescale 1ns/1ns
interface csbm_ram_if;
	import csbm_pkg::*;
	logic [GPR_AW-1:0] addr;
	logic              wr_en;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;
	modport ctrl (output addr, output wr_en, output wdata, input rdata);
	modport mem (input addr, input wr_en, input wdata, output rdata);
endinterface

// file: verification/csbm_bank0_sva.sv
`timescale 1ns/1ns
module csbm_bank0_sva
	import csbm_pkg::*;
(
	// clock, reset and core path
	input wire logic                        CLOCK,
	input wire logic                        SYS_RST,
	input wire logic                        POWER_RST_KIND,
	input wire logic [csbm_pkg::ADDR_W-1:0] ADDR,
	input wire logic                        RD_EN,
	input wire logic                        WR_EN,
	input wire logic [csbm_pkg::DATA_W-1:0] WR_DATA,
	input wire logic [csbm_pkg::DATA_W-1:0] RD_DATA,
	// watched registers
	input wire logic                        PC_STEP,
	input wire logic [csbm_pkg::PC_W-1:0]   PC,
	input wire logic [csbm_pkg::DATA_W-1:0] PORT_B_LATCH,
	input wire logic [csbm_pkg::DATA_W-1:0] STATUS
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (SYS_RST);
	wire bank0 = !STATUS[STAT_RP0];
	a_rst_pc_zero: assert property ($fell(SYS_RST) |->
		PC == 13'h0000 && RD_DATA == 8'h00)
		else $error("pc or read data not cleared");
	a_power_status: assert property ($fell(SYS_RST) && $past(POWER_RST_KIND) |->
		STATUS == STATUS_POWER_RST)
		else $error("status wrong after power reset");
	a_other_status: assert property ($fell(SYS_RST) && !$past(POWER_RST_KIND) |->
		STATUS[7:5] == 3'h0)
		else $error("status top bits wrong after other reset");
	a_pc_step: assert property (PC_STEP && !(WR_EN && ADDR == OFS_PC_LOW) |=>
		PC == PC_W'($past(PC) + 1))
		else $error("pc did not step");
	a_pc_load: assert property (WR_EN && ADDR == OFS_PC_LOW && !PC_STEP |=>
		PC[7:0] == $past(WR_DATA))
		else $error("pc low not loaded");
	a_port_b_write: assert property (WR_EN && ADDR == OFS_PORT_B && bank0 |=>
		PORT_B_LATCH == $past(WR_DATA))
		else $error("port b latch not loaded");
	a_unimpl_zero: assert property (RD_EN && bank0 &&
		ADDR inside {[7'h07:7'h09], [7'h0d:7'h1d]} |=> RD_DATA == 8'h00)
		else $error("unimplemented read not zero");
	a_status_shared: assert property (WR_EN && ADDR == OFS_STATUS |=>
		STATUS[7:5] == $past(WR_DATA[7:5]))
		else $error("status write ignored");
endmodule
bind csbm_bank0 csbm_bank0_sva chk_u (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
	.POWER_RST_KIND(POWER_RST_KIND), .ADDR(ADDR), .RD_EN(RD_EN), .WR_EN(WR_EN),
	.WR_DATA(WR_DATA), .RD_DATA(RD_DATA), .PC_STEP(PC_STEP), .PC(PC),
	.PORT_B_LATCH(PORT_B_LATCH), .STATUS(STATUS));

// file: verification/csbm_core_model.sv
`timescale 1ns/1ns
module csbm_core_model
	import csbm_pkg::*;
(
	// clock and answer
	input wire logic                        clk,
	input wire logic [csbm_pkg::DATA_W-1:0] rd_data,
	// operand requests
	output logic     [csbm_pkg::ADDR_W-1:0] addr,
	output logic                            rd_en,
	output logic                            wr_en,
	output logic     [csbm_pkg::DATA_W-1:0] wr_data
);
	initial
	begin
		addr = 7'h00;
		rd_en = 1'b0;
		wr_en = 1'b0;
		wr_data = 8'h00;
	end
	// write strobe held until the taking edge
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
		wr_data <= ~d;
		#1;
	endtask
	// answer sampled once the taking edge has settled
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		d = rd_data;
	endtask
endmodule

// file: verification/tb_csbm_bank0.sv
`timescale 1ns/1ns
module tb_csbm_bank0;
	import csbm_pkg::*;
	logic        clk, rst, pwr, tmo, step, rd_en, wr_en;
	logic [6:0]  addr;
	logic [7:0]  wr_data, rd_data, pins, lat, status, d;
	logic        pd, cdone;
	logic [7:0]  cval, cctl, ictl, tval;
	logic [4:0]  pa_pins, pa_lat;
	logic [12:0] pc;
	logic [6:0]  gaps [4] = '{7'h07, 7'h09, 7'h0d, 7'h1d};
	int          error_cnt = 0;
	int          comparisons = 0;
	csbm_core_model core_u (.clk(clk), .rd_data(rd_data), .addr(addr), .rd_en(rd_en),
		.wr_en(wr_en), .wr_data(wr_data));
	csbm_bank0 dut_u (.CLOCK(clk), .SYS_RST(rst), .POWER_RST_KIND(pwr),
		.TIMEOUT_FLAG(tmo), .POWERDOWN_FLAG(pd), .ADDR(addr), .RD_EN(rd_en),
		.WR_EN(wr_en), .WR_DATA(wr_data), .RD_DATA(rd_data), .PC_STEP(step), .PC(pc),
		.PORT_A_PINS(pa_pins), .PORT_A_LATCH(pa_lat), .PORT_B_PINS(pins),
		.PORT_B_LATCH(lat), .CONV_DONE(cdone), .CONV_VALUE(cval), .CONV_CTRL(cctl),
		.INT_CTRL(ictl), .TIMER_VALUE(tval), .STATUS(status));
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic chk(input logic [12:0] got, input logic [12:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic do_reset(input logic kind, input int n);
		@(posedge clk);
		rst <= 1'b1;
		pwr <= kind;
		repeat (n) @(posedge clk);
		rst <= 1'b0;
		#1;
	endtask
	task automatic t_power;
		core_u.rd(OFS_STATUS, d);
		chk(d, STATUS_POWER_RST);
		chk(pc, 13'h0000);
		$display("test power done");
	endtask
	task automatic t_indirect;
		core_u.wr(OFS_GPR_LOW, 8'h55);
		core_u.wr(OFS_POINTER, 8'h20);
		core_u.rd(OFS_INDIRECT, d);
		chk(d, 8'h55);
		core_u.wr(OFS_INDIRECT, 8'haa);
		core_u.rd(OFS_GPR_LOW, d);
		chk(d, 8'haa);
		$display("test indirect done");
	endtask
	task automatic t_ports_gaps;
		core_u.wr(OFS_PORT_B, 8'ha5);
		chk(lat, 8'ha5);
		core_u.rd(OFS_PORT_B, d);
		chk(d, 8'h3c);
		foreach (gaps[i])
		begin
			core_u.wr(gaps[i], 8'hff);
			core_u.rd(gaps[i], d);
			chk(d, 8'h00);
		end
		$display("test ports and gaps done");
	endtask
	task automatic t_bank_pc;
		core_u.wr(OFS_STATUS, 8'h20);
		core_u.rd(OFS_PORT_B, d);
		chk(d, 8'h00);
		core_u.wr(OFS_PC_LATCH, 8'h13);
		core_u.wr(OFS_PC_LOW, 8'hfe);
		chk(pc, 13'h13fe);
		core_u.wr(OFS_STATUS, 8'h00);
		@(posedge clk);
		step <= 1'b1;
		@(posedge clk);
		step <= 1'b0;
		#1;
		chk(pc, 13'h13ff);
		$display("test bank and pc done");
	endtask
	// peripheral registers, converter done racing a flag clear
	task automatic t_periph;
		core_u.wr(OFS_TIMER, 8'h5a);
		core_u.rd(OFS_TIMER, d);
		chk(d, 8'h5a);
		chk(tval, 8'h5a);
		core_u.wr(OFS_INT_CTRL, 8'h81);
		chk(ictl, 8'h81);
		core_u.wr(OFS_PORT_A, 8'hff);
		chk(pa_lat, 5'h1f);
		core_u.rd(OFS_PORT_A, d);
		chk(d, 8'h15);
		core_u.wr(OFS_CONV_CTRL, 8'hff);
		chk(cctl, 8'hfd);
		fork
			core_u.wr(OFS_PER_FLAGS, 8'h00);
			begin
				@(posedge clk);
				cval <= 8'h77;
				cdone <= 1'b1;
				@(posedge clk);
				cdone <= 1'b0;
			end
		join
		chk(cctl, 8'hf9);
		core_u.rd(OFS_PER_FLAGS, d);
		chk(d, 8'h40);
		core_u.rd(OFS_CONV_RES, d);
		chk(d, 8'h77);
		$display("test peripherals done");
	endtask
	task automatic t_other_reset;
		@(posedge clk);
		tmo <= 1'b1;
		pd <= 1'b0;
		do_reset(1'b0, 2);
		chk(status, 8'h10);
		chk(lat, 8'ha5);
		chk(pc, 13'h0000);
		chk(ictl, 8'h01);
		chk(pa_lat, 5'h10);
		chk(tval, 8'h5a);
		chk(cctl, 8'h00);
		core_u.rd(OFS_POINTER, d);
		chk(d, 8'h20);
		core_u.rd(OFS_CONV_RES, d);
		chk(d, 8'h77);
		@(posedge clk);
		tmo <= 1'b0;
		pd <= 1'b1;
		do_reset(1'b0, 1);
		chk(status, 8'h08);
		$display("test other reset done");
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		rst = 1'b1;
		pwr = 1'b1;
		tmo = 1'b0;
		pd = 1'b0;
		cdone = 1'b0;
		cval = 8'h00;
		step = 1'b0;
		pins = 8'h3c;
		pa_pins = 5'h15;
		do_reset(1'b1, 7);
		t_power();
		t_indirect();
		t_ports_gaps();
		t_bank_pc();
		t_periph();
		t_other_reset();
		report_and_stop();
	end
	initial
	begin
		#100000;
		error_cnt++;
		$display("ERROR %0t: watchdog expired", $time);
		report_and_stop();
	end
endmodule
